/* File: rtl/hsc_path.sv */
// hsc_path: update timing, temperature compensation, fine gain and offset
// assumes one clock, samples synchronous to it, parameters loaded from nvm
`timescale 1ns/1ns

module hsc_path #(
  parameter int unsigned PER_LO_CYC  = hsc_pkg::PER_LO,
  parameter int unsigned PER_MID_CYC = hsc_pkg::PER_MID,
  parameter int unsigned PER_HI_CYC  = hsc_pkg::PER_HI,
  parameter int unsigned DLY_LO_CYC  = hsc_pkg::DLY_LO,
  parameter int unsigned DLY_MID_CYC = hsc_pkg::DLY_MID,
  parameter int unsigned DLY_HI_CYC  = hsc_pkg::DLY_HI
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              nvm_load_i,
  input  wire logic [3:0]                        nvm_coarse_range_code_i,
  input  wire logic [4:0]                        nvm_coarse_center_code_i,
  input  wire logic [1:0]                        nvm_bandwidth_code_i,
  input  wire logic signed [hsc_pkg::COEF_W-1:0] nvm_offset_drift_coef_i,
  input  wire logic signed [hsc_pkg::COEF_W-1:0] nvm_gain_drift1_hot_i,
  input  wire logic signed [hsc_pkg::COEF_W-1:0] nvm_gain_drift1_cold_i,
  input  wire logic signed [hsc_pkg::COEF_W-1:0] nvm_gain_drift2_hot_i,
  input  wire logic signed [hsc_pkg::COEF_W-1:0] nvm_gain_drift2_cold_i,
  input  wire logic [hsc_pkg::SMP_W-1:0]         nvm_fine_gain_i,
  input  wire logic signed [hsc_pkg::SMP_W-1:0]  nvm_fine_quiescent_adjust_i,
  input  wire logic signed [hsc_pkg::TMP_W-1:0]  temperature_i,
  input  wire logic signed [hsc_pkg::SMP_W-1:0]  sample_i,
  input  wire logic                              sample_valid_i,
  output logic                                   convert_req_o,
  output logic [3:0]                             coarse_range_o,
  output logic signed [7:0]                      coarse_offset_value_o,
  output logic [11:0]                            full_scale_input_o,
  output logic [9:0]                             sensitivity_out_o,
  output logic signed [hsc_pkg::SMP_W-1:0]       compensated_sample_o,
  output logic signed [hsc_pkg::SMP_W-1:0]       adjusted_sample_o,
  output logic                                   adjusted_valid_o
);
  import hsc_pkg::*;

  localparam logic [CNT_W-1:0] PER_LO_C   = CNT_W'(PER_LO_CYC);
  localparam logic [CNT_W-1:0] PER_MID_C  = CNT_W'(PER_MID_CYC);
  localparam logic [CNT_W-1:0] PER_HI_C   = CNT_W'(PER_HI_CYC);
  // delay left over after the whole periods held in the delay line
  localparam logic [CNT_W-1:0] FRAC_LO_C  = CNT_W'(DLY_LO_CYC - DLY_TICKS * PER_LO_CYC);
  localparam logic [CNT_W-1:0] FRAC_MID_C = CNT_W'(DLY_MID_CYC - DLY_TICKS * PER_MID_CYC);
  localparam logic [CNT_W-1:0] FRAC_HI_C  = CNT_W'(DLY_HI_CYC - DLY_TICKS * PER_HI_CYC);
  localparam logic [2:0]       DEPTH_C    = 3'(DLY_DEPTH);

  function automatic logic [CNT_W-1:0] pick_bw(input logic [1:0]       bw,
                                               input logic [CNT_W-1:0] lo, mid, hi);
    case (bw)
      BW_LO:   pick_bw = lo;
      BW_MID:  pick_bw = mid;
      default: pick_bw = hi;
    endcase
  endfunction

  // parameter shadows
  logic [3:0]               range_code;
  logic [4:0]               center_code;
  logic [1:0]               bw_code;
  logic signed [COEF_W-1:0] ofs_coef;
  logic signed [COEF_W-1:0] tc1_hot;
  logic signed [COEF_W-1:0] tc1_cold;
  logic signed [COEF_W-1:0] tc2_hot;
  logic signed [COEF_W-1:0] tc2_cold;
  logic [SMP_W-1:0]         gain_code;
  logic signed [SMP_W-1:0]  quiescent_adj;

  // update timing
  logic [CNT_W-1:0]         upd_cnt;
  logic [CNT_W-1:0]         rel_cnt;
  logic                     rel_armed;

  // sequencer
  hsc_state_t               state;
  hsc_state_t               next_state;
  logic signed [SMP_W-1:0]  y_in;
  logic signed [TMP_W-1:0]  dt;
  logic signed [SMP_W-1:0]  line [DLY_DEPTH];
  logic [2:0]               fill;

  wire logic                     tick;
  wire logic [CNT_W-1:0]         per_cyc;
  wire logic [CNT_W-1:0]         frac_cyc;
  wire logic                     release_now;
  wire logic                     hot;
  wire logic signed [COEF_W-1:0] tc1_sel;
  wire logic signed [COEF_W-1:0] tc2_sel;
  wire logic signed [TMP_W-1:0]  dt_now;
  wire logic signed [WIDE_W-1:0] k1_term;
  wire logic [SMP_W-1:0]         gain_mult;
  wire logic signed [SMP_W-1:0]  comp_now;
  wire logic signed [SMP_W-1:0]  adj_now;
  wire logic signed [SMP_W-1:0]  adj_res;
  wire logic [7:0]               center_frac;
  wire logic [21:0]              sens_prod;

  hsc_mac_if mac_bus ();

  hsc_sat_mac u_mac (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .mac     (mac_bus.unit)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      range_code    <= RANGE_RST;
      center_code   <= CENTER_RST;
      bw_code       <= BW_RST;
      ofs_coef      <= '0;
      tc1_hot       <= '0;
      tc1_cold      <= '0;
      tc2_hot       <= '0;
      tc2_cold      <= '0;
      gain_code     <= GAIN_RST;
      quiescent_adj <= '0;
    end
    else if (nvm_load_i)
    begin
      range_code    <= nvm_coarse_range_code_i;
      center_code   <= nvm_coarse_center_code_i;
      bw_code       <= nvm_bandwidth_code_i;
      ofs_coef      <= nvm_offset_drift_coef_i;
      tc1_hot       <= nvm_gain_drift1_hot_i;
      tc1_cold      <= nvm_gain_drift1_cold_i;
      tc2_hot       <= nvm_gain_drift2_hot_i;
      tc2_cold      <= nvm_gain_drift2_cold_i;
      gain_code     <= nvm_fine_gain_i;
      quiescent_adj <= nvm_fine_quiescent_adjust_i;
    end
  end

  assign per_cyc  = pick_bw(bw_code, PER_LO_C, PER_MID_C, PER_HI_C);
  assign frac_cyc = pick_bw(bw_code, FRAC_LO_C, FRAC_MID_C, FRAC_HI_C);
  assign tick     = (upd_cnt == '0);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      upd_cnt <= '0;
    else if (tick)
      upd_cnt <= per_cyc - CNT_W'(1);
    else
      upd_cnt <= upd_cnt - CNT_W'(1);
  end

  assign release_now = rel_armed && (rel_cnt == '0);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rel_cnt   <= '0;
      rel_armed <= 1'b0;
    end
    else if (tick)
    begin
      rel_cnt   <= frac_cyc - CNT_W'(1);
      rel_armed <= 1'b1;
    end
    else if (release_now)
      rel_armed <= 1'b0;
    else if (rel_armed)
      rel_cnt <= rel_cnt - CNT_W'(1);
  end

  assign dt_now  = temperature_i - T_REF_C;
  assign hot     = (dt > $signed(10'sh000));
  assign tc1_sel = hot ? tc1_hot : tc1_cold;
  assign tc2_sel = hot ? tc2_hot : tc2_cold;
  // each order is its own term, zero turns it off
  assign k1_term = WIDE_W'(tc1_sel) * WIDE_W'(dt) <<< K1_SH;
  // code offset by half scale: 0 -> 2048/2048, 2048 -> 0
  assign gain_mult = gain_code ^ GAIN_FLIP;
  assign comp_now  = sat_smp(mac_bus.result);
  assign adj_res   = sat_smp(mac_bus.result);
  // lowest bit dropped at highest bandwidth
  assign adj_now   = (bw_code >= BW_HI) ? (adj_res & 12'shFFE) : adj_res;

  // operand selection per step; every step after ST_DT2 reads the previous result
  always_comb
  begin
    mac_bus.mul_a  = '0;
    mac_bus.mul_b  = '0;
    mac_bus.addend = '0;
    mac_bus.shift  = NO_SH;
    case (state)
      ST_DT2:
      begin
        mac_bus.mul_a = WIDE_W'(dt);
        mac_bus.mul_b = WIDE_W'(dt);
      end
      ST_K:
      begin
        mac_bus.mul_a  = WIDE_W'(tc2_sel);
        mac_bus.mul_b  = mac_bus.result;
        mac_bus.addend = k1_term;
      end
      ST_GAIN:
      begin
        // y plus y times gain factor
        mac_bus.mul_a  = WIDE_W'(y_in);
        mac_bus.mul_b  = mac_bus.result;
        mac_bus.addend = WIDE_W'(y_in);
        mac_bus.shift  = K_SH;
      end
      ST_OFS:
      begin
        // drift code counts in span-scaled steps
        mac_bus.mul_a  = WIDE_W'(ofs_coef);
        mac_bus.mul_b  = WIDE_W'(dt);
        mac_bus.addend = mac_bus.result;
        mac_bus.shift  = OFS_SH;
      end
      ST_FINE:
      begin
        // fine gain times compensated plus fine offset
        mac_bus.mul_a  = WIDE_W'(comp_now);
        mac_bus.mul_b  = WIDE_W'({1'b0, gain_mult});
        // fine offset up to half scale
        mac_bus.addend = WIDE_W'(quiescent_adj);
        mac_bus.shift  = GAIN_SH;
      end
      default: mac_bus.shift = NO_SH;
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (tick) next_state = ST_WAIT;
      ST_WAIT: if (sample_valid_i) next_state = ST_DT2;
      ST_DT2:  next_state = ST_K;
      ST_K:    next_state = ST_GAIN;
      ST_GAIN: next_state = ST_OFS;
      ST_OFS:  next_state = ST_FINE;
      ST_FINE: next_state = ST_PUSH;
      ST_PUSH: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // capture 12-bit sample with its temperature
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      y_in <= '0;
      dt   <= '0;
    end
    else if ((state == ST_WAIT) && sample_valid_i)
    begin
      y_in <= sample_i;
      dt   <= dt_now;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fill <= '0;
      for (int i = 0; i < DLY_DEPTH; i++)
        line[i] <= '0;
    end
    else if (state == ST_PUSH)
    begin
      line[0] <= adj_now;
      for (int i = 1; i < DLY_DEPTH; i++)
        line[i] <= line[i-1];
      if (fill != DEPTH_C)
        fill <= fill + 3'h1;
    end
  end

  // centre code to signed 1/64 of input span
  assign center_frac = (8'(center_code) - CENTER_ZERO) << 2;
  assign sens_prod   = 22'(gain_mult) * 22'(coarse_sens(range_code));

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      convert_req_o         <= 1'b0;
      coarse_range_o        <= RANGE_RST;
      coarse_offset_value_o <= '0;
      full_scale_input_o    <= '0;
      sensitivity_out_o     <= '0;
      compensated_sample_o  <= '0;
      adjusted_sample_o     <= '0;
      adjusted_valid_o      <= 1'b0;
    end
    else
    begin
      convert_req_o         <= tick;
      coarse_range_o        <= range_code;
      coarse_offset_value_o <= $signed(center_frac);
      full_scale_input_o    <= range_gauss(range_code);
      // range code zero with gain code zero gives 100 thousandths %/G
      sensitivity_out_o     <= sens_prod[20:11];
      if (state == ST_FINE)
        compensated_sample_o <= comp_now;
      // emit sample pushed five ticks ago
      adjusted_valid_o      <= release_now && (fill == DEPTH_C);
      if (release_now && (fill == DEPTH_C))
        adjusted_sample_o <= line[DLY_DEPTH-1];
    end
  end
endmodule // hsc_path

/* File: rtl/hsc_pkg.sv */
// hsc_pkg: constants, state codes and helpers of the hall signal conditioning path
// assumes one 250 MHz clock and signed two's complement samples
package hsc_pkg;
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SMP_W      = 12;
  localparam int unsigned WIDE_W     = 24;
  localparam int unsigned CNT_W      = 20;
  localparam int unsigned TMP_W      = 10;
  localparam int unsigned COEF_W     = 8;

  // internal update rates in Hz
  localparam int unsigned UPD_HZ_LO  = 2000;
  localparam int unsigned UPD_HZ_MID = 8000;
  localparam int unsigned UPD_HZ_HI  = 16000;
  localparam int unsigned PER_LO     = CLK_HZ / UPD_HZ_LO;
  localparam int unsigned PER_MID    = CLK_HZ / UPD_HZ_MID;
  localparam int unsigned PER_HI     = CLK_HZ / UPD_HZ_HI;

  // signal path delay in microseconds
  localparam int unsigned DLY_US_LO  = 2800;
  localparam int unsigned DLY_US_MID = 700;
  localparam int unsigned DLY_US_HI  = 350;
  localparam int unsigned DLY_LO     = CYC_PER_US * DLY_US_LO;
  localparam int unsigned DLY_MID    = CYC_PER_US * DLY_US_MID;
  localparam int unsigned DLY_HI     = CYC_PER_US * DLY_US_HI;
  // whole update periods inside the delay, and delay line depth
  localparam int unsigned DLY_TICKS  = 5;
  localparam int unsigned DLY_DEPTH  = 6;

  localparam logic [1:0] BW_LO  = 2'h0;
  localparam logic [1:0] BW_MID = 2'h1;
  localparam logic [1:0] BW_HI  = 2'h2;

  localparam logic signed [TMP_W-1:0] T_REF_C = 10'sh019;
  localparam logic [3:0]  RANGE_RST   = 4'h0;
  localparam logic [4:0]  CENTER_RST  = 5'h10;
  localparam logic [7:0]  CENTER_ZERO = 8'h10;
  localparam logic [11:0] GAIN_RST    = 12'h000;
  localparam logic [11:0] GAIN_FLIP   = 12'h800;
  localparam logic [1:0]  BW_RST      = 2'h0;

  // fixed point shifts of the arithmetic steps
  localparam logic [4:0] K1_SH   = 5'h06;
  localparam logic [4:0] K_SH    = 5'h16;
  localparam logic [4:0] OFS_SH  = 5'h06;
  localparam logic [4:0] GAIN_SH = 5'h0B;
  localparam logic [4:0] NO_SH   = 5'h00;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WAIT = 8'h02,
    ST_DT2  = 8'h04,
    ST_K    = 8'h08,
    ST_GAIN = 8'h10,
    ST_OFS  = 8'h20,
    ST_FINE = 8'h40,
    ST_PUSH = 8'h80
  } hsc_state_t;

  // input span in gauss per range code; code 0 is the default span
  function automatic logic [11:0] range_gauss(input logic [3:0] code);
    case (code)
      4'h0:    range_gauss = 12'h1F4;
      4'h1:    range_gauss = 12'h064;
      4'h2:    range_gauss = 12'h096;
      4'h3:    range_gauss = 12'h0C8;
      4'h4:    range_gauss = 12'h0FA;
      4'h5:    range_gauss = 12'h12C;
      4'h6:    range_gauss = 12'h15E;
      4'h7:    range_gauss = 12'h190;
      4'h8:    range_gauss = 12'h258;
      4'h9:    range_gauss = 12'h2EE;
      4'hA:    range_gauss = 12'h3E8;
      4'hB:    range_gauss = 12'h4E2;
      4'hC:    range_gauss = 12'h5DC;
      4'hD:    range_gauss = 12'h6D6;
      4'hE:    range_gauss = 12'h7D0;
      default: range_gauss = 12'h8CA;
    endcase
  endfunction

  // coarse sensitivity in 0.001 %FULL_SCALE_OUTPUT per gauss, the inverse of the span
  function automatic logic [9:0] coarse_sens(input logic [3:0] code);
    case (code)
      4'h0:    coarse_sens = 10'h064;
      4'h1:    coarse_sens = 10'h1F4;
      4'h2:    coarse_sens = 10'h14D;
      4'h3:    coarse_sens = 10'h0FA;
      4'h4:    coarse_sens = 10'h0C8;
      4'h5:    coarse_sens = 10'h0A7;
      4'h6:    coarse_sens = 10'h08F;
      4'h7:    coarse_sens = 10'h07D;
      4'h8:    coarse_sens = 10'h053;
      4'h9:    coarse_sens = 10'h043;
      4'hA:    coarse_sens = 10'h032;
      4'hB:    coarse_sens = 10'h028;
      4'hC:    coarse_sens = 10'h021;
      4'hD:    coarse_sens = 10'h01D;
      4'hE:    coarse_sens = 10'h019;
      default: coarse_sens = 10'h016;
    endcase
  endfunction

  // clip a wide value to the sample word
  function automatic logic signed [SMP_W-1:0] sat_smp(input logic signed [WIDE_W-1:0] v);
    if (v > $signed(24'h0007FF))
      sat_smp = 12'sh7FF;
    else if (v < $signed(24'hFFF800))
      sat_smp = 12'sh800;
    else
      sat_smp = v[SMP_W-1:0];
  endfunction
endpackage

/* File: rtl/hsc_mac_if.sv */
// hsc_mac_if: operands and result of the shared multiply-add unit
// driven by the sequencer of the conditioning path
`timescale 1ns/1ns
interface hsc_mac_if;
  import hsc_pkg::*;
  logic signed [WIDE_W-1:0] mul_a;
  logic signed [WIDE_W-1:0] mul_b;
  logic signed [WIDE_W-1:0] addend;
  logic        [4:0]        shift;
  logic signed [WIDE_W-1:0] result;
  modport ctrl (output mul_a, output mul_b, output addend, output shift, input result);
  modport unit (input mul_a, input mul_b, input addend, input shift, output result);
endinterface

/* File: rtl/hsc_sat_mac.sv */
// hsc_sat_mac: registered (a*b >>> shift) + addend, clipped to the wide word
// one cycle from operands to result; operands come over hsc_mac_if
`timescale 1ns/1ns
module hsc_sat_mac (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  hsc_mac_if.unit   mac
);
  import hsc_pkg::*;

  localparam int unsigned PW = 2 * WIDE_W;
  localparam logic signed [PW-1:0] MAX_V = {{(WIDE_W+1){1'b0}}, {(WIDE_W-1){1'b1}}};
  localparam logic signed [PW-1:0] MIN_V = ~MAX_V;

  wire logic signed [PW-1:0]     prod;
  wire logic signed [PW-1:0]     sum;
  wire logic signed [WIDE_W-1:0] clipped;

  assign prod    = PW'(mac.mul_a) * PW'(mac.mul_b);
  assign sum     = (prod >>> mac.shift) + PW'(mac.addend);
  // clip instead of wrap so an overdriven field pins at full scale
  assign clipped = (sum > MAX_V) ? MAX_V[WIDE_W-1:0] :
                   (sum < MIN_V) ? MIN_V[WIDE_W-1:0] : sum[WIDE_W-1:0];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      mac.result <= '0;
    else
      mac.result <= clipped;
  end
endmodule // hsc_sat_mac

/* File: verification/hsc_path_properties.sv */
// hsc_path_properties: port-level timing and value checks of hsc_path
// assumes the bind below hands on the path's timing parameters
`timescale 1ns/1ns
module hsc_path_properties #(
  parameter int unsigned PER_LO_CYC  = hsc_pkg::PER_LO,
  parameter int unsigned PER_MID_CYC = hsc_pkg::PER_MID,
  parameter int unsigned PER_HI_CYC  = hsc_pkg::PER_HI,
  parameter int unsigned DLY_LO_CYC  = hsc_pkg::DLY_LO,
  parameter int unsigned DLY_MID_CYC = hsc_pkg::DLY_MID,
  parameter int unsigned DLY_HI_CYC  = hsc_pkg::DLY_HI
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               nvm_load_i,
  input wire logic [3:0]         nvm_coarse_range_code_i,
  input wire logic [4:0]         nvm_coarse_center_code_i,
  input wire logic [1:0]         nvm_bandwidth_code_i,
  input wire logic [11:0]        nvm_fine_gain_i,
  input wire logic               sample_valid_i,
  input wire logic               convert_req_o,
  input wire logic [3:0]         coarse_range_o,
  input wire logic signed [7:0]  coarse_offset_value_o,
  input wire logic [11:0]        full_scale_input_o,
  input wire logic [9:0]         sensitivity_out_o,
  input wire logic signed [11:0] compensated_sample_o,
  input wire logic signed [11:0] adjusted_sample_o,
  input wire logic               adjusted_valid_o
);
  logic [19:0] gap;
  logic [1:0]  guard;
  logic [1:0]  up;
  logic [1:0]  bw_sh;
  wire  [19:0] per_cyc  = (bw_sh == 2'h0) ? 20'(PER_LO_CYC) :
                          (bw_sh == 2'h1) ? 20'(PER_MID_CYC) : 20'(PER_HI_CYC);
  wire  [19:0] dly_cyc  = (bw_sh == 2'h0) ? 20'(DLY_LO_CYC) :
                          (bw_sh == 2'h1) ? 20'(DLY_MID_CYC) : 20'(DLY_HI_CYC);
  wire  [19:0] frac_cyc = dly_cyc - 20'h00005 * per_cyc;

  // checks skip two requests after a load; the old rate may still run
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      gap   <= 20'h00000;
      guard <= 2'h2;
      up    <= 2'h0;
      bw_sh <= 2'h0;
    end
    else
    begin
      gap   <= convert_req_o ? 20'h00001 : gap + 20'h00001;
      up    <= (up == 2'h3) ? up : up + 2'h1;
      bw_sh <= nvm_load_i ? nvm_bandwidth_code_i : bw_sh;
      guard <= nvm_load_i ? 2'h2 : (convert_req_o && guard != 2'h0) ? guard - 2'h1 : guard;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_took;
    $past(sample_valid_i, 6);
  endsequence

  a_req_pulse: assert property (convert_req_o |=> !convert_req_o)
    else $error("convert request longer than one cycle");
  a_tick_period: assert property (convert_req_o && guard == 2'h0 |-> gap == per_cyc)
    else $error("update period does not match bandwidth code");
  a_out_delay: assert property (adjusted_valid_o && guard == 2'h0 |-> gap == frac_cyc)
    else $error("adjusted sample off its path delay");
  a_valid_pulse: assert property (adjusted_valid_o |=> !adjusted_valid_o)
    else $error("adjusted valid longer than one cycle");
  a_adj_moves: assert property ($changed(adjusted_sample_o) |-> adjusted_valid_o)
    else $error("adjusted sample moved without valid");
  a_comp_moves: assert property ($changed(compensated_sample_o) |-> s_took)
    else $error("compensated sample moved without a taken sample");
  a_range_load: assert property (nvm_load_i |-> ##2 coarse_range_o == $past(nvm_coarse_range_code_i, 2))
    else $error("range output does not follow load");
  a_center_load: assert property (nvm_load_i |-> ##2
    coarse_offset_value_o == {1'b0, $past(nvm_coarse_center_code_i, 2), 2'b00} - 8'h40)
    else $error("coarse offset does not follow centre code");
  a_range_hold: assert property ($changed(coarse_range_o) |-> $past(nvm_load_i, 2))
    else $error("range output changed without load");
  a_default_span: assert property (up == 2'h3 && coarse_range_o == 4'h0 |-> full_scale_input_o == 12'h1F4)
    else $error("range code zero is not 500 gauss");
  a_gain_mute: assert property (nvm_load_i && nvm_fine_gain_i == 12'h800 |-> ##2 sensitivity_out_o == 10'h000)
    else $error("gain code 2048 does not mute sensitivity");
endmodule // hsc_path_properties

bind hsc_path hsc_path_properties #(
  .PER_LO_CYC(PER_LO_CYC), .PER_MID_CYC(PER_MID_CYC), .PER_HI_CYC(PER_HI_CYC),
  .DLY_LO_CYC(DLY_LO_CYC), .DLY_MID_CYC(DLY_MID_CYC), .DLY_HI_CYC(DLY_HI_CYC)
) u_props (
  .clk_i, .rst_n_i, .nvm_load_i, .nvm_coarse_range_code_i, .nvm_coarse_center_code_i,
  .nvm_bandwidth_code_i, .nvm_fine_gain_i, .sample_valid_i, .convert_req_o, .coarse_range_o,
  .coarse_offset_value_o, .full_scale_input_o, .sensitivity_out_o, .compensated_sample_o,
  .adjusted_sample_o, .adjusted_valid_o
);

/* File: verification/hsc_fe_model.sv */
// hsc_fe_model: converter side of the path, one sample per convert request
// assumes requests are one-cycle pulses and lag stays below one update period
`timescale 1ns/1ns
module hsc_fe_model (
  input  wire logic               clk_i,
  input  wire logic               convert_req_i,
  input  wire logic [3:0]         lag_i,
  input  wire logic signed [11:0] value_i,
  output logic signed [11:0]      sample_o,
  output logic                    sample_valid_o
);
  initial
  begin
    sample_o = 12'h000;
    sample_valid_o = 1'b0;
    forever
    begin
      @(negedge clk_i);
      if (convert_req_i)
      begin
        repeat (lag_i) @(negedge clk_i);
        sample_o = value_i;
        sample_valid_o = 1'b1;
        @(negedge clk_i);
        sample_valid_o = 1'b0;
        // released word must not look like the last sample
        sample_o = ~value_i;
      end
    end
  end
endmodule // hsc_fe_model

/* File: verification/hsc_path_test.sv */
// hsc_path_test: self-checking bench of hsc_path with the converter model
// assumes shortened update periods and delays keeping the 8:2:1 ratio
`timescale 1ns/1ns
module hsc_path_test;
  typedef struct {int t, h1, c1, h2, c2, of, y, g, q, bw;} hsc_case_t;
  localparam int PL = 400, PM = 100, PH = 50;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                nvm_load_i = 1'b0;
  logic [3:0]          nvm_coarse_range_code_i = 4'h0;
  logic [4:0]          nvm_coarse_center_code_i = 5'h10;
  logic [1:0]          nvm_bandwidth_code_i = 2'h0;
  logic signed [7:0]   nvm_offset_drift_coef_i = 8'h00;
  logic signed [7:0]   nvm_gain_drift1_hot_i = 8'h00;
  logic signed [7:0]   nvm_gain_drift1_cold_i = 8'h00;
  logic signed [7:0]   nvm_gain_drift2_hot_i = 8'h00;
  logic signed [7:0]   nvm_gain_drift2_cold_i = 8'h00;
  logic [11:0]         nvm_fine_gain_i = 12'h000;
  logic signed [11:0]  nvm_fine_quiescent_adjust_i = 12'h000;
  logic signed [9:0]   temperature_i = 10'h019;
  logic signed [11:0]  sample_i;
  logic                sample_valid_i;
  logic                convert_req_o;
  logic [3:0]          coarse_range_o;
  logic signed [7:0]   coarse_offset_value_o;
  logic [11:0]         full_scale_input_o;
  logic [9:0]          sensitivity_out_o;
  logic signed [11:0]  compensated_sample_o;
  logic signed [11:0]  adjusted_sample_o;
  logic                adjusted_valid_o;
  logic [3:0]          lag = 4'h0;
  logic signed [11:0]  yv = 12'h000;
  int                  num_errors = 0;
  int                  total_checks = 0;
  int                  k;
  longint              c;
  longint              e;
  time                 t0;
  hsc_case_t           cs;
  int                  span[16] = '{500, 100, 150, 200, 250, 300, 350, 400, 600, 750, 1000,
                                    1250, 1500, 1750, 2000, 2250};
  int                  per[4] = '{PL, PM, PH, PH};
  // temp, drift 1 hot/cold, drift 2 hot/cold, offset drift, sample, gain, quiescent, bw
  hsc_case_t           cases[7] = '{'{25, 20, -20, 10, -10, 40, 1000, 0, 100, 1},
                                    '{85, 20, -30, 0, 7, 0, 100, 2048, -500, 1},
                                    '{-15, 20, -30, 7, 12, 0, 80, 1024, 0, 0},
                                    '{85, 0, 0, 10, 0, -41, -200, 0, 0, 2},
                                    '{125, 0, 0, 0, 0, 127, 2000, 2047, 0, 1},
                                    '{-40, 0, 0, 0, 0, 127, -2000, 0, -1, 1},
                                    '{25, 0, 0, 0, 0, 0, 1001, 0, 0, 3}};

  always #2 clk_i = ~clk_i;

  hsc_path #(.PER_LO_CYC(PL), .PER_MID_CYC(PM), .PER_HI_CYC(PH), .DLY_LO_CYC(8 * 280),
    .DLY_MID_CYC(2 * 280), .DLY_HI_CYC(280)) u_dut (
    .clk_i, .rst_n_i, .nvm_load_i, .nvm_coarse_range_code_i, .nvm_coarse_center_code_i,
    .nvm_bandwidth_code_i, .nvm_offset_drift_coef_i, .nvm_gain_drift1_hot_i,
    .nvm_gain_drift1_cold_i, .nvm_gain_drift2_hot_i, .nvm_gain_drift2_cold_i,
    .nvm_fine_gain_i, .nvm_fine_quiescent_adjust_i, .temperature_i, .sample_i,
    .sample_valid_i, .convert_req_o, .coarse_range_o, .coarse_offset_value_o,
    .full_scale_input_o, .sensitivity_out_o, .compensated_sample_o, .adjusted_sample_o,
    .adjusted_valid_o);

  hsc_fe_model u_fe (.clk_i, .convert_req_i(convert_req_o), .lag_i(lag), .value_i(yv),
    .sample_o(sample_i), .sample_valid_o(sample_valid_i));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // outputs follow a load two edges later
  task automatic load();
    @(negedge clk_i);
    nvm_load_i = 1'b1;
    @(negedge clk_i);
    nvm_load_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      k = 0;
      @(negedge clk_i);
      while (convert_req_o !== 1'b1 && k < 1000)
      begin
        @(negedge clk_i);
        k++;
      end
      chk(24'(k < 1000), 24'h000001);
    end
  endtask

  function automatic longint sat(input longint v);
    return (v > 2047) ? 2047 : (v < -2048) ? -2048 : v;
  endfunction

  function automatic longint comp_ref(input hsc_case_t s);
    longint d;
    longint m;
    d = s.t - 25;
    m = (d > 0) ? s.h2 * d * d + ((s.h1 * d) <<< 6) : s.c2 * d * d + ((s.c1 * d) <<< 6);
    return sat(s.y + ((s.y * m) >>> 22) + ((s.of * d) >>> 6));
  endfunction

  // about six and a half times the expected run
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(full_scale_input_o, 500);
    chk(sensitivity_out_o, 100);
    chk(coarse_offset_value_o, 0);
    for (int i = 0; i < 16; i++)
    begin
      nvm_coarse_range_code_i = 4'(i);
      nvm_coarse_center_code_i = 5'(2 * i + i % 2);
      load();
      chk(full_scale_input_o, 24'(span[i]));
      chk(sensitivity_out_o, 24'((50000 + span[i] / 2) / span[i]));
      chk(coarse_offset_value_o, 24'((2 * i + i % 2 - 16) * 4));
    end
    nvm_coarse_range_code_i = 4'h0;
    foreach (cases[i])
    begin
      cs = cases[i];
      nvm_gain_drift1_hot_i = 8'(cs.h1);
      nvm_gain_drift1_cold_i = 8'(cs.c1);
      nvm_gain_drift2_hot_i = 8'(cs.h2);
      nvm_gain_drift2_cold_i = 8'(cs.c2);
      nvm_offset_drift_coef_i = 8'(cs.of);
      nvm_fine_gain_i = 12'(cs.g);
      nvm_fine_quiescent_adjust_i = 12'(cs.q);
      nvm_bandwidth_code_i = 2'(cs.bw);
      temperature_i = 10'(cs.t);
      yv = 12'(cs.y);
      lag = 4'(i);
      load();
      ticks(7);
      c = comp_ref(cs);
      chk(compensated_sample_o, 24'(c));
      t0 = $time;
      ticks(1);
      chk(24'(($time - t0) / 4), 24'(per[cs.bw]));
      if ((100 * (cs.g ^ 2048)) % 2048 == 0)
        chk(sensitivity_out_o, 24'((100 * (cs.g ^ 2048)) / 2048));
      k = 0;
      while (adjusted_valid_o !== 1'b1 && k < 4000)
      begin
        @(negedge clk_i);
        k++;
      end
      chk(24'(k < 4000), 24'h000001);
      e = sat(((c * (cs.g ^ 2048)) >>> 11) + cs.q);
      if (cs.bw >= 2)
        e = e & ~64'sd1;
      chk(adjusted_sample_o, 24'(e));
    end
    close_out();
  end
endmodule // hsc_path_test
